// ### src/rxsc_pkg.sv
// constants for the receive status and receiver control block
package rxsc_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] LAST_OFS = 8'h08;
    // control register fields
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_PASSBAD_BIT = 16;
    localparam logic CTRL_ENABLE_RST  = 1'b0;
    localparam logic CTRL_PASSBAD_RST = 1'b0;
    // status register fields
    localparam int STAT_ERR_BIT    = 0;
    localparam int STAT_HALTED_BIT = 1;
    localparam int STAT_BUSY_BIT   = 2;
    // receive status word positions
    localparam int SW_FILTER   = 30;
    localparam int SW_LEN_LO   = 16;
    localparam int SW_ES       = 15;
    localparam int SW_BCAST    = 13;
    localparam int SW_LENERR   = 12;
    localparam int SW_RUNT     = 11;
    localparam int SW_MCAST    = 10;
    localparam int SW_TOOLONG  = 7;
    localparam int SW_LATECOL  = 6;
    localparam int SW_TYPE     = 5;
    localparam int SW_WDOG     = 4;
    localparam int SW_MIIERR   = 3;
    localparam int SW_DRIBBLE  = 2;
    localparam int SW_CRC      = 1;
    localparam logic [31:0] SW_RSVD_MASK = 32'h8000_4301;
    // frame size limits in bytes
    localparam logic [13:0] RUNT_BYTES  = 14'd64;
    localparam logic [13:0] MAX_BYTES   = 14'd1518;
    localparam logic [13:0] HDR_BYTES   = 14'd14;
    localparam logic [13:0] OVERHEAD    = 14'd18;
    localparam logic [15:0] TYPE_MIN    = 16'd1500;
    localparam logic [15:0] MIN_PAYLOAD = 16'd46;
    localparam int WDOG_LO = 2048;
    localparam int WDOG_HI = 2560;
    // dribble bit thresholds
    localparam logic [2:0] DRIB_MII = 3'd4;
    localparam logic [2:0] DRIB_10M = 3'd3;
    // frame state machine
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RECV  = 3'b001,
        ST_DRAIN = 3'b010,
        ST_PUSH  = 3'b011,
        ST_HALT  = 3'b100
    } rxsc_state_e;
endpackage

// ### src/rxsc_status_ctrl.sv
// receive status word builder, receiver stop/start and error flag
`timescale 1ns/10ps
// Function
// - reserved status bits always read zero
// - bit 30 flags address filter failure
// - bits 29:16 hold frame byte count
// - bit 15 ORs runt, long, latecol, CRC
// - bit 13 flags broadcast destination
// - bit 12 flags length field mismatch
// - bit 11 runt; delivered only if passbad
// - bit 10 flags multicast destination
// - bit 7 over 1518 bytes, no truncation
// - bit 6 flags late collision
// - bit 5 type over 1500, never short runts
// - bit 4 receive watchdog expired
// - bit 3 RX_ER seen during frame
// - bit 2 dribble by mode, not latecol
// - bit 1 CRC mismatch or RX_ER
// - one halted pulse once receiver stops
// - host may flush, then re-enable resumes
// - error flag on underruns or status overrun
// - reception continues after error flag
// - status written after frame data stored
module rxsc_status_ctrl #(
    parameter int WDOG_BYTES = 2048       // watchdog byte limit
) (
    input  wire logic        sys_clk,          // 40 MHz clock
    input  wire logic        arst_n,           // async reset, low
    input  wire logic        hsel,             // AHB slave select
    input  wire logic [31:0] haddr,            // AHB address
    input  wire logic [1:0]  htrans,           // AHB transfer type
    input  wire logic        hwrite,           // AHB write
    input  wire logic [2:0]  hsize,            // AHB size
    input  wire logic [31:0] hwdata,           // AHB write data
    input  wire logic        hready,           // AHB bus ready
    output logic             hreadyout,        // AHB slave ready
    output logic             hresp,            // AHB response
    output logic [31:0]      hrdata,           // AHB read data
    input  wire logic        frameStart,       // front end frame begin
    input  wire logic        byteStrobe,       // one received byte
    input  wire logic        frameEnd,         // front end frame end
    input  wire logic        miiRxEr,          // MII receive error
    input  wire logic        filterFail,       // failed address filter
    input  wire logic        dstBroadcast,     // broadcast destination
    input  wire logic        dstMulticast,     // multicast destination
    input  wire logic        lateCollision,    // late collision seen
    input  wire logic        crcBad,           // CRC mismatch
    input  wire logic [15:0] lengthType,       // length/type field
    input  wire logic [2:0]  dribbleBits,      // bits after last byte
    input  wire logic        speed10,          // 10 Mbps mode
    input  wire logic        dataDone,         // frame data in data fifo
    input  wire logic        stsFull,          // status fifo full
    input  wire logic        dataUnderrun,     // host data fifo underrun
    input  wire logic        stsUnderrun,      // host status underrun
    output logic             receiveEnable,    // receiver accepts frames
    output logic             stsWrite,         // status fifo write
    output logic [31:0]      stsWord,          // status word
    output logic             frameDrop,        // discard runt frame
    output logic             receiverHaltedPulse, // receiver stopped
    output logic             receiveErrorFlag  // sticky error flag
);
    if (WDOG_BYTES < rxsc_pkg::WDOG_LO ||
        WDOG_BYTES > rxsc_pkg::WDOG_HI) begin : badWdog
        $error("WDOG_BYTES out of range");
    end
    localparam logic [13:0] WDOG_LIM = 14'(WDOG_BYTES);

    function automatic logic [13:0] satInc(input logic [13:0] v);
        satInc = (v == 14'h3FFF) ? v : v + 14'd1;
    endfunction

    // ---------------- bus slave ----------------
    logic        enable_reg, enable_next;
    logic        passBad_reg, passBad_next;
    logic        err_reg, err_next;
    logic [31:0] last_reg, last_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        wrPend_reg, wrPend_next;
    logic [7:0]  wrAddr_reg, wrAddr_next;
    logic        busAddr;
    logic        errClear;
    logic        errEvent;
    rxsc_pkg::rxsc_state_e state_reg, state_next;

    assign busAddr = hsel && htrans[1] && hready;
    assign errClear = wrPend_reg && wrAddr_reg == rxsc_pkg::STAT_OFS
                      && hwdata[rxsc_pkg::STAT_ERR_BIT];

    always_comb begin
        enable_next  = enable_reg;
        passBad_next = passBad_reg;
        err_next     = err_reg;
        last_next    = last_reg;
        rdata_next   = rdata_reg;
        wrPend_next  = busAddr && hwrite;
        wrAddr_next  = busAddr ? haddr[7:0] : wrAddr_reg;
        if (wrPend_reg && wrAddr_reg == rxsc_pkg::CTRL_OFS) begin
            enable_next  = hwdata[rxsc_pkg::CTRL_ENABLE_BIT];
            passBad_next = hwdata[rxsc_pkg::CTRL_PASSBAD_BIT];
        end
        // a new error wins over a clear in the same cycle
        if (errClear)
            err_next = 1'b0;
        if (errEvent)
            err_next = 1'b1;
        if (stsWrite)
            last_next = stsWord;
        if (busAddr && !hwrite) begin
            rdata_next = 32'h0000_0000;
            case (haddr[7:0])
                rxsc_pkg::CTRL_OFS: begin
                    rdata_next[rxsc_pkg::CTRL_ENABLE_BIT]  = enable_reg;
                    rdata_next[rxsc_pkg::CTRL_PASSBAD_BIT] = passBad_reg;
                end
                rxsc_pkg::STAT_OFS: begin
                    rdata_next[rxsc_pkg::STAT_ERR_BIT] = err_reg;
                    rdata_next[rxsc_pkg::STAT_HALTED_BIT] =
                        (state_reg == rxsc_pkg::ST_HALT);
                    rdata_next[rxsc_pkg::STAT_BUSY_BIT] =
                        (state_reg != rxsc_pkg::ST_IDLE) &&
                        (state_reg != rxsc_pkg::ST_HALT);
                end
                rxsc_pkg::LAST_OFS: rdata_next = last_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg  <= rxsc_pkg::CTRL_ENABLE_RST;
            passBad_reg <= rxsc_pkg::CTRL_PASSBAD_RST;
            err_reg     <= 1'b0;
            last_reg    <= 32'h0000_0000;
            rdata_reg   <= 32'h0000_0000;
            wrPend_reg  <= 1'b0;
            wrAddr_reg  <= 8'h00;
        end else begin
            enable_reg  <= enable_next;
            passBad_reg <= passBad_next;
            err_reg     <= err_next;
            last_reg    <= last_next;
            rdata_reg   <= rdata_next;
            wrPend_reg  <= wrPend_next;
            wrAddr_reg  <= wrAddr_next;
        end
    end

    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign hrdata           = rdata_reg;
    assign receiveEnable    = enable_reg;
    assign receiveErrorFlag = err_reg;

    // ---------------- frame status ----------------
    logic [13:0] count_reg, count_next;
    logic        rxErSeen_reg, rxErSeen_next;
    logic        dataSeen_reg, dataSeen_next;
    logic [31:0] word_reg, word_next;
    logic        halt_reg, halt_next;
    logic        drop_reg, drop_next;
    logic        runt, tooLong, wdog, typeFrame, lenErr, dribble;
    logic        rxErAll;
    logic [15:0] expected;

    always_comb begin
        runt      = count_reg < rxsc_pkg::RUNT_BYTES;
        tooLong   = count_reg > rxsc_pkg::MAX_BYTES;
        wdog      = count_reg > WDOG_LIM;
        typeFrame = (lengthType > rxsc_pkg::TYPE_MIN) &&
                    (count_reg >= rxsc_pkg::HDR_BYTES);
        expected  = (lengthType < rxsc_pkg::MIN_PAYLOAD) ?
                    {2'b00, rxsc_pkg::RUNT_BYTES} :
                    lengthType + {2'b00, rxsc_pkg::OVERHEAD};
        lenErr    = !runt && (lengthType <= rxsc_pkg::TYPE_MIN) &&
                    (expected != {2'b00, count_reg});
        dribble   = !lateCollision && (speed10 ?
                    (dribbleBits >= rxsc_pkg::DRIB_10M) :
                    (dribbleBits == rxsc_pkg::DRIB_MII));
        rxErAll   = rxErSeen_reg || miiRxEr;
    end

    always_comb begin
        state_next    = state_reg;
        count_next    = count_reg;
        rxErSeen_next = rxErSeen_reg;
        dataSeen_next = dataSeen_reg;
        word_next     = word_reg;
        halt_next     = 1'b0;
        drop_next     = 1'b0;
        case (state_reg)
            rxsc_pkg::ST_IDLE: begin
                if (!enable_reg) begin
                    state_next = rxsc_pkg::ST_HALT;
                    halt_next  = 1'b1;
                end else if (frameStart) begin
                    state_next    = rxsc_pkg::ST_RECV;
                    count_next    = 14'd0;
                    rxErSeen_next = 1'b0;
                    dataSeen_next = 1'b0;
                end
            end
            rxsc_pkg::ST_RECV: begin
                if (byteStrobe)
                    count_next = satInc(count_reg);
                if (miiRxEr)
                    rxErSeen_next = 1'b1;
                if (dataDone)
                    dataSeen_next = 1'b1;
                if (frameEnd) begin
                    state_next = rxsc_pkg::ST_DRAIN;
                    word_next  = 32'h0000_0000;
                    word_next[rxsc_pkg::SW_FILTER]  = filterFail;
                    word_next[29:16]                = count_next;
                    word_next[rxsc_pkg::SW_BCAST]   = dstBroadcast;
                    word_next[rxsc_pkg::SW_MCAST]   = dstMulticast;
                    word_next[rxsc_pkg::SW_LATECOL] = lateCollision;
                    word_next[rxsc_pkg::SW_MIIERR]  = rxErAll;
                    word_next[rxsc_pkg::SW_CRC] = crcBad || rxErAll;
                    word_next[rxsc_pkg::SW_DRIBBLE] = dribble;
                end
            end
            rxsc_pkg::ST_DRAIN: begin
                // length-derived flags use the final byte count
                word_next[rxsc_pkg::SW_RUNT]    = runt;
                word_next[rxsc_pkg::SW_TOOLONG] = tooLong;
                word_next[rxsc_pkg::SW_WDOG]    = wdog;
                word_next[rxsc_pkg::SW_TYPE]    = typeFrame;
                word_next[rxsc_pkg::SW_LENERR]  = lenErr;
                word_next[rxsc_pkg::SW_ES] = runt || tooLong ||
                    word_reg[rxsc_pkg::SW_LATECOL] ||
                    word_reg[rxsc_pkg::SW_CRC];
                word_next = word_next & ~rxsc_pkg::SW_RSVD_MASK;
                if (dataDone || dataSeen_reg) begin
                    dataSeen_next = 1'b1;
                    state_next    = rxsc_pkg::ST_PUSH;
                end
            end
            rxsc_pkg::ST_PUSH: begin
                state_next = rxsc_pkg::ST_IDLE;
                drop_next  = word_reg[rxsc_pkg::SW_RUNT] && !passBad_reg;
            end
            rxsc_pkg::ST_HALT: begin
                if (enable_reg)
                    state_next = rxsc_pkg::ST_IDLE;
            end
            default: state_next = rxsc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= rxsc_pkg::ST_IDLE;
            count_reg    <= 14'd0;
            rxErSeen_reg <= 1'b0;
            dataSeen_reg <= 1'b0;
            word_reg     <= 32'h0000_0000;
            halt_reg     <= 1'b0;
            drop_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            rxErSeen_reg <= rxErSeen_next;
            dataSeen_reg <= dataSeen_next;
            word_reg     <= word_next;
            halt_reg     <= halt_next;
            drop_reg     <= drop_next;
        end
    end

    // runt frames are withheld unless bad frames pass
    assign stsWrite = (state_reg == rxsc_pkg::ST_PUSH) &&
                      !(word_reg[rxsc_pkg::SW_RUNT] && !passBad_reg);
    assign stsWord  = word_reg;
    assign frameDrop = drop_reg;
    assign receiverHaltedPulse = halt_reg;
    assign errEvent = dataUnderrun || stsUnderrun ||
                      (stsWrite && stsFull);

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_reserved_zero: assert property (
        stsWrite |-> (stsWord & rxsc_pkg::SW_RSVD_MASK) == 32'h0)
        else $error("reserved status bit set");
    chk_es_summary: assert property (
        stsWrite |-> stsWord[15] == (stsWord[11] || stsWord[7] ||
                                     stsWord[6] || stsWord[1]))
        else $error("error summary wrong");
    chk_length_field: assert property (
        stsWrite |-> stsWord[29:16] == count_reg)
        else $error("length field differs from count");
    chk_halt_single: assert property (
        receiverHaltedPulse |=> !receiverHaltedPulse &&
                                state_reg == rxsc_pkg::ST_HALT)
        else $error("halt pulse not single");
    chk_type_runt: assert property (
        stsWrite && stsWord[29:16] < 14'd14 |-> !stsWord[5])
        else $error("type bit set on short runt");
    chk_dribble_latecol: assert property (
        stsWrite && stsWord[6] |-> !stsWord[2])
        else $error("dribble set with late collision");
    chk_err_sticky: assert property (
        receiveErrorFlag && !errClear |=> receiveErrorFlag)
        else $error("error flag dropped without clear");
    chk_overrun_err: assert property (
        stsWrite && stsFull |=> receiveErrorFlag)
        else $error("overrun did not raise error");
    chk_runt_withheld: assert property (
        stsWrite && stsWord[11] |-> passBad_reg)
        else $error("runt delivered without passbad");
    chk_status_after_data: assert property (
        stsWrite |-> dataSeen_reg)
        else $error("status before data");
    chk_rxer_crc: assert property (
        stsWrite && stsWord[3] |-> stsWord[1])
        else $error("RX_ER not reflected in CRC bit");
    chk_restart: assert property (
        state_reg == rxsc_pkg::ST_HALT && enable_reg
        |=> state_reg == rxsc_pkg::ST_IDLE)
        else $error("receiver did not resume");

    chk_filter_bit: assert property (
        state_reg == rxsc_pkg::ST_RECV && frameEnd
        |=> stsWord[30] == $past(filterFail))
        else $error("filter bit lost");

    chk_bcast_bit: assert property (
        state_reg == rxsc_pkg::ST_RECV && frameEnd
        |=> stsWord[13] == $past(dstBroadcast))
        else $error("broadcast bit lost");

    chk_rxer_seen: assert property (
        state_reg == rxsc_pkg::ST_RECV && miiRxEr
        |=> rxErSeen_reg)
        else $error("RX_ER not remembered");

    chk_byte_count: assert property (
        state_reg == rxsc_pkg::ST_RECV && byteStrobe && count_reg != 14'h3FFF
        |=> count_reg == $past(count_reg) + 14'd1)
        else $error("byte not counted");

    chk_push_resume: assert property (
        state_reg == rxsc_pkg::ST_PUSH
        |=> state_reg == rxsc_pkg::ST_IDLE)
        else $error("receiver did not return to idle");

    chk_underrun_err: assert property (
        dataUnderrun || stsUnderrun
        |=> receiveErrorFlag)
        else $error("underrun did not raise error");

    chk_halt_pulse: assert property (
        state_reg == rxsc_pkg::ST_IDLE && !enable_reg
        |=> receiverHaltedPulse)
        else $error("no halt pulse");

    chk_runt_drop: assert property (
        state_reg == rxsc_pkg::ST_PUSH && !stsWrite
        |=> frameDrop)
        else $error("withheld runt not dropped");

    chk_type_bit: assert property (
        stsWrite && stsWord[29:16] >= rxsc_pkg::HDR_BYTES
        |-> stsWord[5] == (lengthType > rxsc_pkg::TYPE_MIN))
        else $error("frame type bit wrong");

    chk_len_mismatch: assert property (
        stsWrite && (stsWord[11] || lengthType > rxsc_pkg::TYPE_MIN)
        |-> !stsWord[12])
        else $error("length error on runt or typed frame");

endmodule

// ### tb/rxsc_host_model.sv
// host side model: status fifo that the host pops, with flush
`timescale 1ns/10ps
module rxsc_host_model #(
    parameter int DEPTH = 4                 // status fifo depth
) (
    input  wire logic        sys_clk,       // clock
    input  wire logic        arst_n,        // async reset, low
    input  wire logic        stsWrite,      // status word push
    input  wire logic [31:0] stsWord,       // pushed word
    input  wire logic        popReq,        // host pops one word
    input  wire logic        flush,         // host clears the fifo
    output logic             stsFull,       // fifo full
    output logic             stsUnderrun,   // pop while empty
    output logic [31:0]      popWord        // popped word
);
    logic [31:0] q[$];
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q.delete();
            stsUnderrun <= 1'b0;
            popWord     <= 32'h0000_0000;
        end else begin
            stsUnderrun <= 1'b0;
            popWord     <= ~popWord;
            if (flush) begin
                q.delete();
            end else begin
                // a push into a full fifo is lost, as the real one
                if (stsWrite && q.size() < DEPTH) q.push_back(stsWord);
                if (popReq && q.size() == 0) stsUnderrun <= 1'b1;
                else if (popReq) popWord <= q.pop_front();
            end
        end
        stsFull <= (q.size() >= DEPTH);
    end
endmodule

// ### tb/testbench.sv
// self-checking bench of the receive status and control block
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, frameStart = 0;
    logic byteStrobe = 0, frameEnd = 0, miiRxEr = 0, filterFail = 0;
    logic dstBroadcast = 0, dstMulticast = 0, lateCollision = 0;
    logic crcBad = 0, speed10 = 0, dataDone = 0, dataUnderrun = 0;
    logic popReq = 0, flush = 0;
    logic [31:0] haddr = 0, hwdata = 0, r = 32'hB357_2473, rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2, dribbleBits = 0;
    logic [15:0] lengthType = 0;
    logic        hreadyout, hresp, receiveEnable, stsWrite, frameDrop;
    logic        receiverHaltedPulse, receiveErrorFlag, stsFull, stsUnderrun;
    logic        gotW;
    logic [31:0] hrdata, stsWord, popWord, popped;
    int miscompares = 0, n_compared = 0, haltCnt = 0, dropCnt = 0, len, i;
    int clen[7] = '{13, 14, 63, 64, 1518, 1519, 2049};
    logic [15:0] clt[7] = '{16'h05DD, 16'h05DD, 16'h001E, 16'h002E,
                            16'h05DC, 16'h05DD, 16'h05DC};
    rxsc_status_ctrl #(.WDOG_BYTES(2048)) rxsc_status_ctrl_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .frameStart(frameStart), .byteStrobe(byteStrobe),
        .frameEnd(frameEnd), .miiRxEr(miiRxEr), .filterFail(filterFail),
        .dstBroadcast(dstBroadcast), .dstMulticast(dstMulticast),
        .lateCollision(lateCollision), .crcBad(crcBad),
        .lengthType(lengthType), .dribbleBits(dribbleBits),
        .speed10(speed10), .dataDone(dataDone), .stsFull(stsFull),
        .dataUnderrun(dataUnderrun), .stsUnderrun(stsUnderrun),
        .receiveEnable(receiveEnable), .stsWrite(stsWrite),
        .stsWord(stsWord), .frameDrop(frameDrop),
        .receiverHaltedPulse(receiverHaltedPulse),
        .receiveErrorFlag(receiveErrorFlag));
    rxsc_host_model #(.DEPTH(4)) rxsc_host_model_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .stsWrite(stsWrite),
        .stsWord(stsWord), .popReq(popReq), .flush(flush),
        .stsFull(stsFull), .stsUnderrun(stsUnderrun), .popWord(popWord));
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (receiverHaltedPulse === 1'b1) haltCnt++;
    always @(posedge sys_clk) if (frameDrop === 1'b1) dropCnt++;
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] exp_sw(int n, logic [6:0] f,
                                           logic [15:0] lt, logic [2:0] dr);
        logic [31:0] w;
        logic        runt, crc;
        runt = n < 64;
        crc = f[4] | f[5];
        w = 32'h0000_0000;
        w[rxsc_pkg::SW_FILTER] = f[0];
        w[29:16] = 14'(n);
        w[rxsc_pkg::SW_BCAST] = f[1];
        w[rxsc_pkg::SW_MCAST] = f[2];
        w[rxsc_pkg::SW_LATECOL] = f[3];
        w[rxsc_pkg::SW_CRC] = crc;
        w[rxsc_pkg::SW_MIIERR] = f[5];
        w[rxsc_pkg::SW_RUNT] = runt;
        w[rxsc_pkg::SW_TOOLONG] = n > 1518;
        w[rxsc_pkg::SW_WDOG] = n > 2048;
        w[rxsc_pkg::SW_TYPE] = lt > 1500 && n >= 14;
        w[rxsc_pkg::SW_LENERR] = lt <= 1500 && !runt
                                 && n != (lt < 46 ? 64 : lt + 18);
        w[rxsc_pkg::SW_DRIBBLE] = (f[6] ? dr >= 3 : dr == 4) && !f[3];
        w[rxsc_pkg::SW_ES] = runt | (n > 1518) | f[3] | crc;
        return w;
    endfunction
    task cmp(string what, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wait_ready;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
    endtask
    task ahb(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    task pulse_in(int which);
        @(posedge sys_clk);
        if (which == 0) dataUnderrun <= 1'b1;
        else popReq <= 1'b1;
        @(posedge sys_clk);
        dataUnderrun <= 1'b0;
        popReq <= 1'b0;
        @(negedge sys_clk) popped = popWord;
        @(negedge sys_clk);
    endtask
    task do_frame(int n, logic [6:0] f, logic [15:0] lt, logic [2:0] dr,
                  int late, output logic got);
        @(posedge sys_clk);
        frameStart <= 1'b1;
        lengthType <= lt;
        speed10 <= f[6];
        for (int b = 0; b < n; b++) begin
            @(posedge sys_clk);
            frameStart <= 1'b0;
            byteStrobe <= 1'b1;
            miiRxEr <= f[5] && b == n / 2;
        end
        @(posedge sys_clk);
        {byteStrobe, miiRxEr, frameEnd} <= 3'b001;
        {crcBad, lateCollision, dstMulticast, dstBroadcast, filterFail}
            <= f[4:0];
        dribbleBits <= dr;
        dataDone <= (late == 0);
        @(posedge sys_clk);
        frameEnd <= 1'b0;
        dataDone <= 1'b0;
        repeat (late) begin
            @(negedge sys_clk);
            cmp("early stsWrite", 0, stsWrite);
        end
        if (late > 0) @(posedge sys_clk) dataDone <= 1'b1;
        if (late > 0) @(posedge sys_clk) dataDone <= 1'b0;
        got = 1'b0;
        for (int k = 0; k < 10 && !got && frameDrop !== 1'b1; k++) begin
            @(negedge sys_clk);
            got = (stsWrite === 1'b1);
        end
        repeat (2) @(posedge sys_clk);
    endtask
    task check_frame(int n, logic [6:0] f, logic [15:0] lt, logic [2:0] dr,
                     int late);
        do_frame(n, f, lt, dr, late, gotW);
        cmp("status written", 1, gotW);
        pulse_in(1);
        cmp("stsWord", exp_sw(n, f, lt, dr), popped);
    endtask
    initial begin
        #(25 * 80000);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ahb(0, 32'h0, 0, rd);
        cmp("CTRL reset", 0, rd);
        ahb(0, 32'h8, 0, rd);
        cmp("LAST reset", 0, rd);
        ahb(0, 32'hC, 0, rd);
        cmp("unmapped", 0, rd);
        cmp("hresp", 0, hresp);
        cmp("halt pulses", 1, haltCnt);
        ahb(1, 32'h0, 32'h0001_0001, rd);
        ahb(0, 32'h0, 0, rd);
        cmp("CTRL", 32'h0001_0001, rd);
        cmp("receiveEnable", 1, receiveEnable);
        $display("test reset done");
        for (i = 0; i < 14; i++) begin
            r = lfsr(r);
            len = i < 7 ? clen[i] : 14 + int'(r[10:0]);
            r = lfsr(r);
            check_frame(len, r[22:16], i < 7 ? clt[i] : {5'h00, r[10:0]},
                        r[26:24], r[29] ? 3 : 0);
        end
        ahb(0, 32'h8, 0, rd);
        cmp("LAST", exp_sw(len, r[22:16], {5'h00, r[10:0]}, r[26:24]), rd);
        $display("test random frames done");
        ahb(1, 32'h0, 32'h0000_0001, rd);
        do_frame(40, 0, 16'h0020, 0, 0, gotW);
        cmp("runt dropped", 0, gotW);
        cmp("frameDrop pulses", 1, dropCnt);
        ahb(1, 32'h0, 32'h0000_0000, rd);
        repeat (6) @(negedge sys_clk);
        cmp("halt pulses", 2, haltCnt);
        cmp("receiveEnable", 0, receiveEnable);
        do_frame(70, 0, 16'h0800, 0, 0, gotW);
        cmp("halted frame", 0, gotW);
        @(posedge sys_clk) flush <= 1'b1;
        @(posedge sys_clk) flush <= 1'b0;
        ahb(1, 32'h0, 32'h0001_0001, rd);
        check_frame(100, 7'h02, 16'h0800, 0, 0);
        cmp("halt pulses", 2, haltCnt);
        $display("test stop start done");
        pulse_in(0);
        cmp("flag data underrun", 1, receiveErrorFlag);
        check_frame(80, 7'h04, 16'h0032, 0, 0);
        cmp("flag sticky", 1, receiveErrorFlag);
        ahb(0, 32'h4, 0, rd);
        cmp("STAT err", 1, rd[rxsc_pkg::STAT_ERR_BIT]);
        ahb(1, 32'h4, 32'h0000_0001, rd);
        repeat (2) @(negedge sys_clk);
        cmp("flag cleared", 0, receiveErrorFlag);
        for (i = 0; i < 5; i++) do_frame(64, 0, 16'h0800, 0, 0, gotW);
        repeat (2) @(negedge sys_clk);
        cmp("flag overrun", 1, receiveErrorFlag);
        ahb(1, 32'h4, 32'h0000_0001, rd);
        for (i = 0; i < 5; i++) pulse_in(1);
        cmp("flag sts underrun", 1, receiveErrorFlag);
        @(posedge sys_clk) arst_n <= 1'b0;
        @(posedge sys_clk) arst_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp("flag after reset", 0, receiveErrorFlag);
        ahb(1, 32'h0, 32'h0001_0001, rd);
        check_frame(1600, 7'h48, 16'h05DC, 3'h3, 2);
        $display("test error flag done");
        close_out();
    end
endmodule
